// *** odc_map.svh ***
// Register offsets, command codes, span codes and reset values
`ifndef ODC_MAP_SVH
`define ODC_MAP_SVH

// Command field codes
`define ODC_CMD_WR_N 4'h0
`define ODC_CMD_UPD_N 4'h1
`define ODC_CMD_WR_N_UPD_ALL 4'h2
`define ODC_CMD_WR_UPD_N 4'h3
`define ODC_CMD_PD_N 4'h4
`define ODC_CMD_PD_CHIP 4'h5
`define ODC_CMD_SPAN_N 4'h6
`define ODC_CMD_CONFIG 4'h7
`define ODC_CMD_WR_ALL 4'h8
`define ODC_CMD_UPD_ALL 4'h9
`define ODC_CMD_WR_UPD_ALL 4'ha
`define ODC_CMD_MUX 4'hb
`define ODC_CMD_TSEL 4'hc
`define ODC_CMD_GTOG 4'hd
`define ODC_CMD_SPAN_ALL 4'he
`define ODC_CMD_NOP 4'hf

// Span codes
`define ODC_SPAN_U5 3'h0
`define ODC_SPAN_U10 3'h1
`define ODC_SPAN_B5 3'h2
`define ODC_SPAN_B10 3'h3
`define ODC_SPAN_B2P5 3'h4

// Reset values
`define ODC_CODE_ZERO 16'h0000
`define ODC_CODE_MID 16'h8000
`define ODC_STRAP_SOFT 3'h7
`define ODC_MUX_OFF 5'h00
`define ODC_INIT_CYCLES 3'h5

// Register byte offsets and response codes on the bus
`define ODC_REG_STATUS 12'h000
`define ODC_REG_TOGGLE 12'h004
`define ODC_REG_CMD 12'h008
`define ODC_REG_LAST 12'h00c
`define ODC_REG_CHAN 12'h020
`define ODC_RESP_OK 2'h0
`define ODC_RESP_ERR 2'h2

`endif

// *** odc_pkg.sv ***
// Types shared by the converter control block
package odc_pkg;

  // Active state of one channel
  typedef struct packed {
    logic [15:0] code;
    logic [2:0] span;
    logic on;
  } odc_chan_t;

  // One instruction word: command, channel address, data
  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] addr;
    logic [15:0] data;
  } odc_word_t;

  // Start-up sequence
  typedef enum logic [1:0] {
    ODC_INIT_WAIT,
    ODC_INIT_LOAD,
    ODC_RUN
  } odc_init_t;

endpackage : odc_pkg

// *** odc_sync.sv ***
// Three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
module odc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pin side and filtered level
  input wire logic [W-1:0] d,
  output logic [W-1:0] f
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // =========================================
  // Synchroniser chain
  // First stage is read only by the second stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // =========================================
  // Filter: a change counts once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          f[i] <= INIT[i];
        else if (s2[i] == s3[i])
          f[i] <= s3[i];
      end
    end
  endgenerate

endmodule : odc_sync

// *** odc_shift.sv ***
// Serial shift register framed by the load/select line
`timescale 1ns/1ps
module odc_shift (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Filtered serial pins
  input wire logic sck,
  input wire logic sdi,
  input wire logic load_select_n,
  // Received word
  output logic word_valid,
  output odc_pkg::odc_word_t word
);

  logic [31:0] sreg;
  logic sck_q;
  logic cs_q;

  // =========================================
  // Edge history of the serial clock and frame line
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sck_q <= 1'b0;
      cs_q <= 1'b1;
    end
    else
    begin
      sck_q <= sck;
      cs_q <= load_select_n;
    end
  end

  // Shift MSB first on each clock rise inside the frame
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sreg <= 32'h0000_0000;
    else if (!load_select_n && sck && !sck_q)
      sreg <= {sreg[30:0], sdi}; // RULE1 RULE2
  end

  // Frame end: keep only the last 24 bits, so a 32-bit word drops its lead byte
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      word_valid <= 1'b0;
      word <= '0;
    end
    else
    begin
      word_valid <= load_select_n && !cs_q; // RULE5
      if (load_select_n && !cs_q)
        word <= sreg[23:0]; // RULE24 RULE6
    end
  end

endmodule : odc_shift

// *** odc_top.sv ***
// Octal converter control: serial command decode, channel registers, bus slave
//
// Function
// RULE1: Shift SDI on SCK rise while select low
// RULE2: Word is command, address, data, MSB first
// RULE3: Address 0 to 7 selects channel 0 to 7
// RULE4: Twelve-bit variant keeps top twelve data bits
// RULE5: Select rising edge ends and executes word
// RULE6: Optional 32-bit word with eight leading ignored bits
// RULE7: Codes are unsigned straight binary
// RULE8: Writes touch holding registers only
// RULE9: Two code holding registers, default and alternate
// RULE10: Update copies holding to active, powers up
// RULE11: Update copies code and span together
// RULE12: Update from command, update pin, or toggle
// RULE13: Span codes select five output ranges
// RULE14: Span write commands, one channel or all
// RULE15: All straps high: software range, zero 5V
// RULE16: Strap codes fix range and reset code
// RULE17: Monitor command latches five-bit select
// RULE18: Monitor select resets to disabled
// RULE19: Toggle select register, eight bits, reset zero
// RULE20: Toggle uses select bits, global bit, pin
// RULE21: Unused toggling: pin low, select bits zero
// RULE22: Toggle select command steers writes to alternate
// RULE23: Toggle edges update from default or alternate
// RULE24: Decode last 24 bits at frame end
// RULE25: Span writes only in software range mode
`include "odc_map.svh"
`timescale 1ns/1ps
module odc_top #(
  parameter int CODE_BITS = 16,
  parameter int CHANNELS = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial pins
  input wire logic sck,
  input wire logic sdi,
  input wire logic load_select_n,
  // Update, toggle and strap pins
  input wire logic async_update_n,
  input wire logic toggle_pin,
  input wire logic [2:0] range_strap_pins,
  // Channel and monitor state
  output odc_pkg::odc_chan_t [CHANNELS-1:0] chan_out,
  output logic [4:0] monitor_select,
  output logic chip_powered_down,
  // AXI4-Lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // =========================================
  // Pin synchronisers
  logic sck_f;
  logic sdi_f;
  logic cs_f;
  logic upd_f;
  logic tgp_f;
  logic [2:0] strap_f;
  logic ser_valid;
  odc_pkg::odc_word_t ser_word;

  odc_sync #(.W(8), .INIT(8'hfc)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({range_strap_pins, load_select_n, async_update_n, toggle_pin, sdi, sck}),
    .f({strap_f, cs_f, upd_f, tgp_f, sdi_f, sck_f})
  );

  odc_shift u_shift (
    .aclk(aclk),
    .aresetn(aresetn),
    .sck(sck_f),
    .sdi(sdi_f),
    .load_select_n(cs_f),
    .word_valid(ser_valid),
    .word(ser_word)
  );

  // =========================================
  // Start-up: straps are caught after reset release, once synchronised
  odc_pkg::odc_init_t init_state;
  logic [2:0] init_cnt;
  logic soft_mode;
  logic [2:0] strap_span;
  logic [15:0] strap_code;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      init_state <= odc_pkg::ODC_INIT_WAIT;
      init_cnt <= `ODC_INIT_CYCLES;
    end
    else
    begin
      case (init_state)
        odc_pkg::ODC_INIT_WAIT:
        begin
          init_cnt <= init_cnt - 3'h1;
          if (init_cnt == 3'h1)
            init_state <= odc_pkg::ODC_INIT_LOAD;
        end
        odc_pkg::ODC_INIT_LOAD: init_state <= odc_pkg::ODC_RUN;
        odc_pkg::ODC_RUN: init_state <= odc_pkg::ODC_RUN;
        default: init_state <= odc_pkg::ODC_INIT_WAIT;
      endcase
    end
  end

  wire init_load = (init_state == odc_pkg::ODC_INIT_LOAD);
  wire running = (init_state == odc_pkg::ODC_RUN);

  // Strap decode: range and reset code
  always_comb
  begin
    strap_code = `ODC_CODE_MID; // RULE16
    case (strap_f)
      3'h0: strap_span = `ODC_SPAN_B10;
      3'h1: strap_span = `ODC_SPAN_B5;
      3'h2: strap_span = `ODC_SPAN_B2P5;
      3'h3:
      begin
        strap_span = `ODC_SPAN_U10;
        strap_code = `ODC_CODE_ZERO;
      end
      3'h4: strap_span = `ODC_SPAN_U10;
      3'h5:
      begin
        strap_span = `ODC_SPAN_U5;
        strap_code = `ODC_CODE_ZERO;
      end
      3'h6: strap_span = `ODC_SPAN_U5;
      default:
      begin
        strap_span = `ODC_SPAN_U5; // RULE15
        strap_code = `ODC_CODE_ZERO;
      end
    endcase
  end

  // Range mode is fixed once at start-up
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      soft_mode <= 1'b1;
    else if (init_load)
      soft_mode <= (strap_f == `ODC_STRAP_SOFT); // RULE15
  end

  // =========================================
  // Command source: serial frames win, the bus port waits a cycle
  logic bus_cmd;
  logic [23:0] bus_word;
  wire exec = running && (ser_valid || bus_cmd);
  odc_pkg::odc_word_t w;
  assign w = ser_valid ? ser_word : odc_pkg::odc_word_t'(bus_word);

  // Code field: variant keeps the leading bits, trailing bits ignored
  localparam logic [15:0] CODE_MASK = 16'hffff << (16 - CODE_BITS);
  wire [15:0] wcode = w.data & CODE_MASK; // RULE4 RULE7

  // Address decode, out-of-range address selects nothing
  logic [CHANNELS-1:0] addr_sel;
  always_comb
  begin
    addr_sel = '0;
    if (w.addr < 4'(CHANNELS))
      addr_sel[w.addr[2:0]] = 1'b1; // RULE3
  end

  wire c_wr_n = exec && (w.cmd == `ODC_CMD_WR_N || w.cmd == `ODC_CMD_WR_N_UPD_ALL
    || w.cmd == `ODC_CMD_WR_UPD_N);
  wire c_wr_all = exec && (w.cmd == `ODC_CMD_WR_ALL || w.cmd == `ODC_CMD_WR_UPD_ALL);
  wire c_up_n = exec && (w.cmd == `ODC_CMD_UPD_N || w.cmd == `ODC_CMD_WR_UPD_N);
  wire c_up_all = exec && (w.cmd == `ODC_CMD_UPD_ALL || w.cmd == `ODC_CMD_WR_N_UPD_ALL
    || w.cmd == `ODC_CMD_WR_UPD_ALL);
  wire c_sp_n = exec && soft_mode && w.cmd == `ODC_CMD_SPAN_N; // RULE14 RULE25
  wire c_sp_all = exec && soft_mode && w.cmd == `ODC_CMD_SPAN_ALL; // RULE14 RULE25
  wire c_pd_n = exec && w.cmd == `ODC_CMD_PD_N;
  wire c_pd_chip = exec && w.cmd == `ODC_CMD_PD_CHIP;

  // =========================================
  // Toggle control
  logic [CHANNELS-1:0] toggle_select_reg;
  logic global_toggle_bit;
  logic tog_q;
  logic upd_q;
  wire tog_lvl = global_toggle_bit && tgp_f; // RULE20
  wire tog_rise = running && tog_lvl && !tog_q;
  wire tog_fall = running && !tog_lvl && tog_q;
  wire pin_upd = running && !upd_f && upd_q;

  // Toggle select, global bit and monitor select commands
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      toggle_select_reg <= '0; // RULE19 RULE21
      global_toggle_bit <= 1'b0;
      monitor_select <= `ODC_MUX_OFF; // RULE18
    end
    else if (exec)
    begin
      if (w.cmd == `ODC_CMD_TSEL)
        toggle_select_reg <= w.data[CHANNELS-1:0]; // RULE22
      if (w.cmd == `ODC_CMD_GTOG)
        global_toggle_bit <= w.data[0];
      if (w.cmd == `ODC_CMD_MUX)
        monitor_select <= w.data[4:0]; // RULE17
    end
  end

  // Edge history of the toggle level and update pin
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tog_q <= 1'b0;
      upd_q <= 1'b1;
    end
    else
    begin
      tog_q <= tog_lvl;
      upd_q <= upd_f;
    end
  end

  // =========================================
  // Per-channel double-buffered registers
  logic [CHANNELS-1:0] upd_any;
  genvar i;
  generate
    for (i = 0; i < CHANNELS; i++)
    begin : g_ch
      logic [15:0] code_a;
      logic [15:0] code_b;
      logic [2:0] span_in;
      logic [15:0] next_a;
      logic [15:0] next_b;
      logic [2:0] next_span;
      logic wr;
      logic tog_upd;
      logic use_b;

      assign wr = c_wr_all || (c_wr_n && addr_sel[i]);
      assign tog_upd = toggle_select_reg[i] && (tog_rise || tog_fall); // RULE23
      assign upd_any[i] = c_up_all || (c_up_n && addr_sel[i]) || pin_upd || tog_upd; // RULE12
      // Toggle edge picks its register; otherwise select bit and level decide
      assign use_b = tog_upd ? tog_rise : (toggle_select_reg[i] && tog_lvl); // RULE20
      // Same-word write then update sees the new value
      assign next_a = (wr && !toggle_select_reg[i]) ? wcode : code_a; // RULE9
      assign next_b = (wr && toggle_select_reg[i]) ? wcode : code_b; // RULE22
      assign next_span = (c_sp_all || (c_sp_n && addr_sel[i])) ? w.data[2:0] : span_in; // RULE13

      // Holding registers: writes never reach the active side
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          code_a <= `ODC_CODE_ZERO;
          code_b <= `ODC_CODE_ZERO;
          span_in <= `ODC_SPAN_U5;
        end
        else if (init_load)
        begin
          code_a <= strap_code & CODE_MASK;
          code_b <= strap_code & CODE_MASK;
          span_in <= strap_span;
        end
        else
        begin
          code_a <= next_a; // RULE8
          code_b <= next_b; // RULE8
          span_in <= next_span; // RULE8
        end
      end

      // Active registers: code and span copied together on update
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          chan_out[i] <= '0;
        else if (init_load)
        begin
          chan_out[i].code <= strap_code & CODE_MASK; // RULE16
          chan_out[i].span <= strap_span;
          chan_out[i].on <= 1'b1;
        end
        else if (upd_any[i])
        begin
          chan_out[i].code <= use_b ? next_b : next_a; // RULE10 RULE11
          chan_out[i].span <= next_span; // RULE11
          chan_out[i].on <= 1'b1; // RULE10
        end
        else if (c_pd_chip || (c_pd_n && addr_sel[i]))
          chan_out[i].on <= 1'b0;
      end
    end
  endgenerate

  // Chip power-down clears on any channel update
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      chip_powered_down <= 1'b0;
    else if (|upd_any)
      chip_powered_down <= 1'b0; // RULE10
    else if (c_pd_chip)
      chip_powered_down <= 1'b1;
  end

  // Last executed word, for software to inspect
  logic [23:0] last_word;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      last_word <= 24'h00_0000;
    else if (exec)
      last_word <= w;
  end

  // =========================================
  // AXI4-Lite slave: address and data taken together, one cycle answer
  wire wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && running
    && !ser_valid && !bus_cmd;
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  wire wr_is_cmd = (s_axi_awaddr[11:2] == `ODC_REG_CMD >> 2);

  // Command register: a write with the low three byte strobes set is executed like a serial frame
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bus_cmd <= 1'b0;
      bus_word <= 24'h00_0000;
    end
    else
    begin
      // A command that meets a serial word stays pending one more cycle, so it is not lost
      bus_cmd <= (bus_cmd && ser_valid) || (wr_take && wr_is_cmd && (s_axi_wstrb[2:0] == 3'h7));
      if (wr_take && wr_is_cmd)
        bus_word <= s_axi_wdata[23:0];
    end
  end

  // Write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ODC_RESP_OK;
    end
    else if (wr_take)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_is_cmd ? `ODC_RESP_OK : `ODC_RESP_ERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Read decode
  logic [31:0] rd_data;
  logic rd_ok;
  wire [11:0] ra = s_axi_araddr;
  wire [11:0] ch_off = ra - `ODC_REG_CHAN;
  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    if (ra[11:2] == `ODC_REG_STATUS >> 2)
      rd_data = {22'h0, soft_mode, chip_powered_down, ~{chan_out[7].on, chan_out[6].on,
        chan_out[5].on, chan_out[4].on, chan_out[3].on, chan_out[2].on,
        chan_out[1].on, chan_out[0].on}};
    else if (ra[11:2] == `ODC_REG_TOGGLE >> 2)
      rd_data = {18'h0, global_toggle_bit, monitor_select, toggle_select_reg};
    else if (ra[11:2] == `ODC_REG_LAST >> 2)
      rd_data = {8'h00, last_word};
    else if (ra >= `ODC_REG_CHAN && ch_off[11:2] < 10'(CHANNELS))
      rd_data = {12'h000, chan_out[ch_off[4:2]]};
    else
      rd_ok = 1'b0;
  end

  assign s_axi_arready = !s_axi_rvalid;

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ODC_RESP_OK;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_ok ? `ODC_RESP_OK : `ODC_RESP_ERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule : odc_top

// *** odc_top_properties.sv ***
// Port assertions for the converter control block
`timescale 1ns/1ps
module odc_top_properties #(
  parameter int CHANNELS = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pins
  input wire logic load_select_n,
  input wire logic async_update_n,
  input wire logic toggle_pin,
  input wire logic [2:0] range_strap_pins,
  // Channel and monitor state
  input wire odc_pkg::odc_chan_t [CHANNELS-1:0] chan_out,
  input wire logic [4:0] monitor_select,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // =====
  // Helpers
  logic all_on;
  // Every channel powered; an update must bring each one back
  always_comb
  begin
    all_on = 1'b1;
    for (int i = 0; i < CHANNELS; i++)
      all_on = all_on & chan_out[i].on;
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // =====
  // Properties
  property p_mux_reset;
    $rose(aresetn) |-> monitor_select == 5'h00;
  endproperty
  a_mux_reset: assert property (p_mux_reset)
    else $error("monitor select not cleared");
  property p_soft_init;
    $rose(aresetn) && range_strap_pins == 3'h7 |-> ##8 chan_out[0] == 20'h1;
  endproperty
  a_soft_init: assert property (p_soft_init)
    else $error("soft range start wrong");
  property p_strap_init;
    $rose(aresetn) && range_strap_pins == 3'h3 |-> ##8 chan_out[CHANNELS-1] == 20'h3;
  endproperty
  a_strap_init: assert property (p_strap_init)
    else $error("strapped start wrong");
  // Slow synchronisers: only a long quiet stretch inside a frame is judged
  property p_frame_quiet;
    (!load_select_n && async_update_n && !s_axi_awvalid && $stable(toggle_pin)) [*8] |-> $stable(chan_out);
  endproperty
  a_frame_quiet: assert property (p_frame_quiet)
    else $error("channels moved inside a frame");
  property p_update_pin;
    $fell(async_update_n) |-> ##[1:10] all_on;
  endproperty
  a_update_pin: assert property (p_update_pin)
    else $error("update pin did not power up");
  property p_mux_codes;
    $changed(monitor_select) |-> monitor_select inside {5'h00, [5'h10:5'h1c]};
  endproperty
  a_mux_codes: assert property (p_mux_codes)
    else $error("monitor select illegal");
  property p_bus_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
  endproperty
  a_bus_wr: assert property (p_bus_wr)
    else $error("write response late");
  property p_bus_rd;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##1 (!s_axi_rready || !s_axi_rvalid);
  endproperty
  a_bus_rd: assert property (p_bus_rd)
    else $error("read answer wrong");
endmodule : odc_top_properties

bind odc_top odc_top_properties #(.CHANNELS(CHANNELS)) u_props (
  .aclk(aclk), .aresetn(aresetn), .load_select_n(load_select_n), .async_update_n(async_update_n),
  .toggle_pin(toggle_pin), .range_strap_pins(range_strap_pins), .chan_out(chan_out),
  .monitor_select(monitor_select), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready)
);

// *** odc_spi_host.sv ***
// Serial host model driving the frame, clock and data pins
`timescale 1ns/1ps
module odc_spi_host #(
  parameter int HALF_NS = 400
) (
  // Serial pins
  output logic sck,
  output logic sdi,
  output logic load_select_n
);
  // Clock rests low and frame line high between frames
  initial
  begin
    sck = 1'b0;
    sdi = 1'b1;
    load_select_n = 1'b1;
  end

  // Send the low n bits of w; the odd offset keeps edges clear of the bus clock
  task automatic xfer(input logic [31:0] w, input int n);
    #(HALF_NS + 37);
    load_select_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      sdi = w[i];
      #HALF_NS sck = 1'b1;
      #HALF_NS sck = 1'b0;
    end
    #HALF_NS load_select_n = 1'b1;
    sdi = ~sdi; // Released line shows no stale bit
    #(4 * HALF_NS);
  endtask : xfer
endmodule : odc_spi_host

// *** test_octal_dac_serial_control.sv ***
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
`include "odc_map.svh"
module test_octal_dac_serial_control;
  // =====
  // Signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic async_update_n = 1'b1;
  logic toggle_pin = 1'b0;
  logic [2:0] range_strap_pins = 3'h7;
  logic sck, sdi, load_select_n, chip_powered_down;
  odc_pkg::odc_chan_t [7:0] chan_out;
  logic [4:0] monitor_select;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int errors = 0;
  int samples_checked = 0;

  // Bus clock
  always #50 aclk = ~aclk;

  // Every bench signal carries the port name it drives or watches
  odc_top dut (.*);
  odc_spi_host host (.sck(sck), .sdi(sdi), .load_select_n(load_select_n));

  // =====
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : check

  task automatic chk(input int i, input logic [15:0] c, input logic [2:0] s, input logic on, input string m);
    check({12'h000, chan_out[i]}, {12'h000, c, s, on}, m);
  endtask : chk

  function automatic logic [31:0] fw(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
    return {8'h00, c, a, d};
  endfunction : fw

  task automatic frame(input logic [31:0] w, input int n = 24);
    @(posedge aclk);
    host.xfer(w, n);
  endtask : frame

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    while (!(s_axi_awready && s_axi_wready))
      @(posedge aclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (!s_axi_bvalid)
      @(posedge aclk);
    s_axi_bready <= 1'b0;
    check(32'(s_axi_bresp), 32'(er), "write resp");
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    while (!s_axi_arready)
      @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid)
      @(posedge aclk);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    check(32'(s_axi_rresp), 32'(er), "read resp");
  endtask : axi_rd

  task automatic end_of_test;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // =====
  // Scenarios
  task automatic t_init;
    logic [31:0] d;
    for (int i = 0; i < 8; i++)
      chk(i, 16'h0000, 3'h0, 1'b1, "soft start");
    check(32'(monitor_select), 32'h0, "mux start");
    axi_rd(`ODC_REG_TOGGLE, d, `ODC_RESP_OK);
    check(d, 32'h0, "toggle start");
    axi_rd(12'h100, d, `ODC_RESP_ERR);
    axi_wr(`ODC_REG_STATUS, 32'h0, `ODC_RESP_ERR);
  endtask : t_init

  task automatic t_serial;
    logic [31:0] d;
    frame(fw(`ODC_CMD_WR_N, 4'h3, 16'habcd));
    chk(3, 16'h0000, 3'h0, 1'b1, "write only");
    frame(fw(`ODC_CMD_UPD_N, 4'h3, 16'h0000));
    chk(3, 16'habcd, 3'h0, 1'b1, "update n");
    chk(2, 16'h0000, 3'h0, 1'b1, "other chan");
    frame({8'ha5, `ODC_CMD_WR_UPD_N, 4'h7, 16'hfedc}, 32);
    chk(7, 16'hfedc, 3'h0, 1'b1, "long word");
    frame(fw(`ODC_CMD_WR_UPD_N, 4'h8, 16'h1111));
    chk(0, 16'h0000, 3'h0, 1'b1, "bad address");
    axi_wr(`ODC_REG_CMD, fw(`ODC_CMD_WR_UPD_N, 4'h5, 16'h0f0f), `ODC_RESP_OK);
    repeat (3) @(posedge aclk);
    chk(5, 16'h0f0f, 3'h0, 1'b1, "bus cmd");
    axi_rd(`ODC_REG_LAST, d, `ODC_RESP_OK);
    check(d, fw(`ODC_CMD_WR_UPD_N, 4'h5, 16'h0f0f), "last word");
  endtask : t_serial

  task automatic t_span;
    for (int s = 0; s < 5; s++)
    begin
      frame(fw(`ODC_CMD_SPAN_N, 4'h1, 16'(s)));
      frame(fw(`ODC_CMD_UPD_N, 4'h1, 16'h0000));
      chk(1, 16'h0000, 3'(s), 1'b1, "span n");
    end
    frame(fw(`ODC_CMD_SPAN_ALL, 4'h0, 16'h0004));
    chk(3, 16'habcd, 3'h0, 1'b1, "span held");
    frame(fw(`ODC_CMD_UPD_ALL, 4'h0, 16'h0000));
    chk(3, 16'habcd, 3'h4, 1'b1, "span all");
  endtask : t_span

  task automatic t_mux;
    logic [4:0] v;
    for (int m = 16; m <= 29; m++)
    begin
      v = (m == 29) ? 5'h00 : 5'(m);
      frame(fw(`ODC_CMD_MUX, 4'h0, 16'(v)));
      check(32'(monitor_select), 32'(v), "mux");
    end
  endtask : t_mux

  task automatic t_toggle;
    frame(fw(`ODC_CMD_WR_N, 4'h2, 16'h1000));
    frame(fw(`ODC_CMD_TSEL, 4'h0, 16'h0004));
    frame(fw(`ODC_CMD_WR_N, 4'h2, 16'h1068));
    @(posedge aclk);
    toggle_pin <= 1'b1;
    repeat (10) @(posedge aclk);
    chk(2, 16'h0000, 3'h4, 1'b1, "pin alone");
    frame(fw(`ODC_CMD_GTOG, 4'h0, 16'h0001));
    chk(2, 16'h1068, 3'h4, 1'b1, "rise alt");
    chk(3, 16'habcd, 3'h4, 1'b1, "unselected");
    @(posedge aclk);
    toggle_pin <= 1'b0;
    repeat (10) @(posedge aclk);
    chk(2, 16'h1000, 3'h4, 1'b1, "fall default");
    frame(fw(`ODC_CMD_TSEL, 4'h0, 16'h0000));
    frame(fw(`ODC_CMD_GTOG, 4'h0, 16'h0000));
  endtask : t_toggle

  task automatic t_pin_update;
    frame(fw(`ODC_CMD_WR_N, 4'h6, 16'h0777));
    frame(fw(`ODC_CMD_PD_N, 4'h6, 16'h0000));
    chk(6, 16'h0000, 3'h4, 1'b0, "power down");
    frame(fw(`ODC_CMD_PD_CHIP, 4'h0, 16'h0000));
    check(32'(chip_powered_down), 32'h1, "chip down");
    @(posedge aclk);
    async_update_n <= 1'b0;
    repeat (4) @(posedge aclk);
    async_update_n <= 1'b1;
    repeat (10) @(posedge aclk);
    chk(6, 16'h0777, 3'h4, 1'b1, "pin update");
    check(32'(chip_powered_down), 32'h0, "chip up");
  endtask : t_pin_update

  task automatic t_strap;
    logic [2:0] sp [7] = '{3'h3, 3'h2, 3'h4, 3'h1, 3'h1, 3'h0, 3'h0};
    for (int p = 0; p < 7; p++)
    begin
      @(posedge aclk);
      aresetn <= 1'b0;
      range_strap_pins <= 3'(p);
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (12) @(posedge aclk);
      chk(p, (p == 3 || p == 5) ? 16'h0000 : 16'h8000, sp[p], 1'b1, "strap start");
    end
    frame(fw(`ODC_CMD_SPAN_N, 4'h0, 16'h0004));
    frame(fw(`ODC_CMD_UPD_N, 4'h0, 16'h0000));
    chk(0, 16'h8000, 3'h0, 1'b1, "strap span kept");
  endtask : t_strap

  // =====
  // Main sequence and watchdog
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (12) @(posedge aclk);
    t_init();
    t_serial();
    t_span();
    t_mux();
    t_toggle();
    t_pin_update();
    t_strap();
    end_of_test();
  end

  // Cut a hang short well past the expected run
  initial
  begin
    #3000000;
    errors++;
    end_of_test();
  end
endmodule : test_octal_dac_serial_control
